// ### tbd_pkg.sv
// constants shared by the brake, output and burst logic
package tbd_pkg;
    // register byte offsets
    localparam logic [7:0] CTRL_ONE_OFS = 8'h00;
    localparam logic [7:0] CTRL_TWO_OFS = 8'h04;
    localparam logic [7:0] CHAN_EN_OFS = 8'h20;
    localparam logic [7:0] BRAKE_DT_OFS = 8'h44;
    localparam logic [7:0] DMA_CTRL_OFS = 8'h48;
    localparam logic [7:0] DATA_PORT_OFS = 8'h4C;
    // register file geometry
    localparam int REG_COUNT = 32;
    localparam int IDX_W = 5;
    // brake_deadtime_control fields
    localparam int DT_LSB = 0;
    localparam int DT_MSB = 7;
    localparam int LOCK_LSB = 8;
    localparam int LOCK_MSB = 9;
    localparam int IDLE_OFFSTATE_SELECT_BIT = 10;
    localparam int RUN_OFFSTATE_SELECT_BIT = 11;
    localparam int BRAKE_ENABLE_BIT = 12;
    localparam int BRAKE_POLARITY_BIT = 13;
    localparam int AUTO_OUTPUT_ENABLE_BIT = 14;
    localparam int MAIN_OUTPUT_ENABLE_BIT = 15;
    // dma_burst_control fields
    localparam int BASE_LSB = 0;
    localparam int BASE_MSB = 4;
    localparam int LEN_LSB = 8;
    localparam int LEN_MSB = 12;
    localparam logic [15:0] DMA_CTRL_MASK = 16'h1F1F;
    // channel enable register: enable, polarity, compl enable, compl pol
    localparam int CH_EN_OFS = 0;
    localparam int CH_POL_OFS = 1;
    localparam int CH_NEN_OFS = 2;
    localparam int CH_NPOL_OFS = 3;
    localparam int CH_STRIDE = 4;
    // control two: idle level of primary and complementary output
    localparam int IDLE_LSB = 8;
    localparam int IDLE_STRIDE = 2;
    localparam int CHANNELS = 4;
    // reset values
    localparam logic [15:0] BRAKE_DT_RST = 16'h0000;
    localparam logic [15:0] DMA_CTRL_RST = 16'h0000;
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_TWO = 2'h2;
    // dead time window after an enable rises
    localparam int DEAD_NS = 48;
    localparam int CLK_NS = 8;
    localparam logic [7:0] DEAD_CYCLES = 8'((DEAD_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ### tbd_chan_if.sv
// one channel's controls and pin drive between the core and its stage
`timescale 1ns/100ps
interface tbd_chan_if;
    logic mainOn;
    logic runOff;
    logic idleOff;
    logic enP;
    logic enN;
    logic polP;
    logic polN;
    logic idleP;
    logic idleN;
    logic refWave;
    logic outP;
    logic oeP;
    logic outN;
    logic oeN;
    modport ctl(output mainOn, runOff, idleOff, enP, enN, polP, polN,
        idleP, idleN, refWave, input outP, oeP, outN, oeN);
    modport stage(input mainOn, runOff, idleOff, enP, enN, polP, polN,
        idleP, idleN, refWave, output outP, oeP, outN, oeN);
endinterface

// ### tbd_chan_stage.sv
// complementary output stage of one channel with off-state handling
`timescale 1ns/100ps
module tbd_chan_stage (
    input wire logic ref_clk,
    input wire logic srst,
    tbd_chan_if.stage ch
);
    logic enPrev_reg;
    logic [7:0] dead_reg;
    logic inDead;
    logic outP_next;
    logic oeP_next;
    logic outN_next;
    logic oeN_next;

    // dead window starts when the channel goes from no enable set to at least one set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            enPrev_reg <= 1'b0;
            dead_reg <= 8'h00;
        end else begin
            enPrev_reg <= ch.enP | ch.enN;
            if ((ch.enP | ch.enN) & ~enPrev_reg) begin
                // the edge cycle itself is the first dead cycle
                dead_reg <= tbd_pkg::DEAD_CYCLES - 8'h01;
            end else if (dead_reg != 8'h00) begin
                dead_reg <= dead_reg - 8'h01;
            end
        end
    end

    // window opens at the rising enable, so no idle or live level leaks out
    assign inDead = (dead_reg != 8'h00) | ((ch.enP | ch.enN) & ~enPrev_reg);

    // pin drive by mode: run, idle with off-state, or released
    always_comb begin
        outP_next = 1'b0;
        oeP_next = 1'b0;
        outN_next = 1'b0;
        oeN_next = 1'b0;
        if (ch.mainOn) begin
            oeP_next = ch.enP | (ch.runOff & ch.enN);
            oeN_next = ch.enN | (ch.runOff & ch.enP);
            outP_next = (ch.enP & ~inDead) ? (ch.refWave ^ ch.polP) : ch.polP;
            outN_next = (ch.enN & ~inDead) ? (~ch.refWave ^ ch.polN)
                : ch.polN;
        end else if (ch.idleOff & (ch.enP | ch.enN)) begin
            oeP_next = 1'b1;
            oeN_next = 1'b1;
            outP_next = inDead ? ch.polP : ch.idleP;
            outN_next = inDead ? ch.polN : ch.idleN;
        end
    end

    // registered pin drive; released when main output is off, unless idle off-state is set on an enabled channel
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ch.outP <= 1'b0;
            ch.oeP <= 1'b0;
            ch.outN <= 1'b0;
            ch.oeN <= 1'b0;
        end else begin
            ch.outP <= outP_next;
            ch.oeP <= oeP_next;
            ch.outN <= outN_next;
            ch.oeN <= oeN_next;
        end
    end
endmodule // tbd_chan_stage

// ### tbd_brake_burst.sv
// brake, main output enable and burst data port of an advanced timer
// Behaviour
// - with main output off and idle off-state set, an enabled channel drives inactive during dead time, then idle; otherwise stays off.
// - with main output on and run off-state set, a newly enabled channel first drives polarity-adjusted inactive on both outputs; otherwise stays off.
// - the brake pin counts only while brake enable is set, active low at polarity 0 and active high at polarity 1.
// - a new brake polarity takes effect one clock after its write.
// - main output enable is set by software, and also at an update event when auto enable is set and no brake is active.
// - from one clock after main output enable goes to 0, every channel output is off, inactive during dead time, or at its idle level.
// - once main output enable has been 1 and run off-state clear for two clocks, a channel output is driven only where its enable bit was set one clock before.
// - an active brake clears main output enable at once, without a clock edge.
// - at lock level 1 or higher writes to brake enable, brake polarity and auto enable are ignored.
// - the five-bit base field picks the first register of a burst counted from control register one.
// - the five-bit length field gives a burst of length plus one transfers, one to eighteen; the code takes every five-bit value, up to 32 transfers.
// - each access to the data port is one step of a burst over the selected run of registers.
// - bursts work with 16-bit or 8-bit items and still cover the programmed number of registers.
// - the register of each step is control register one plus base plus index.
// - the byte address of each step is control register one plus four times the sum of base and index.
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
module tbd_brake_burst (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic brakeInput,
    input wire logic updateEvent,
    input wire logic [3:0] chanRef,
    output logic [3:0] channelPrimaryOutput,
    output logic [3:0] primaryOe,
    output logic [3:0] channelComplOutput,
    output logic [3:0] complOe,
    output logic mainOutputOn
);
    localparam logic [4:0] BRAKE_IDX = 5'(tbd_pkg::BRAKE_DT_OFS >> 2);
    localparam logic [4:0] DMA_IDX = 5'(tbd_pkg::DMA_CTRL_OFS >> 2);
    localparam logic [4:0] PORT_IDX = 5'(tbd_pkg::DATA_PORT_OFS >> 2);
    localparam logic [4:0] BASE_IDX = 5'(tbd_pkg::CTRL_ONE_OFS >> 2);
    localparam logic [4:0] CHEN_IDX = 5'(tbd_pkg::CHAN_EN_OFS >> 2);
    localparam logic [4:0] CTWO_IDX = 5'(tbd_pkg::CTRL_TWO_OFS >> 2);

    // plain timer register storage reached directly or through bursts
    logic [15:0] timerRegs [tbd_pkg::REG_COUNT];
    logic [7:0] deadTime_reg;
    logic [1:0] lock_reg;
    logic lockDone_reg;
    logic idleOff_reg;
    logic runOff_reg;
    logic brakeEn_reg;
    logic brakePol_reg;
    logic brakePolEff_reg;
    logic autoEn_reg;
    logic moe_reg;
    logic [15:0] dmaCtrl_reg;
    logic [4:0] burstIdx_reg;
    logic [4:0] burstIdx_next;
    logic ack_reg;
    logic [31:0] rdData_reg;
    logic take;
    logic isPort;
    logic outOfMap;
    logic [5:0] stepSum;
    logic [5:0] accIdx;
    logic accValid;
    logic [15:0] accRead;
    logic [15:0] wrMask;
    logic [15:0] wrData;
    logic [15:0] brakeRead;
    logic brakeActive;
    logic swWrite;
    logic brakeWrite;
    logic [4:0] baseField;
    logic [4:0] lenField;

    // bus request taken once, ack follows one cycle later
    assign take = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign outOfMap = wb_adr_i[7];
    assign isPort = ~outOfMap & (wb_adr_i[6:2] == PORT_IDX);
    assign baseField = dmaCtrl_reg[tbd_pkg::BASE_MSB:tbd_pkg::BASE_LSB];
    assign lenField = dmaCtrl_reg[tbd_pkg::LEN_MSB:tbd_pkg::LEN_LSB];

    // burst step target: control one plus base plus index, in words
    assign stepSum = {1'b0, BASE_IDX} + {1'b0, baseField}
        + {1'b0, burstIdx_reg};
    assign accIdx = isPort ? stepSum : {1'b0, wb_adr_i[6:2]};
    assign accValid = ~outOfMap & ~accIdx[5]
        & ~(isPort & (accIdx[4:0] == PORT_IDX));

    // byte-lane mask so 8-bit and 16-bit items both land in place
    assign wrMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wrData = wb_dat_i[15:0];
    assign swWrite = take & wb_we_i & accValid;
    assign brakeWrite = swWrite & (accIdx[4:0] == BRAKE_IDX);

    // brake pin qualified by enable and the delayed polarity
    assign brakeActive = brakeEn_reg
        & (brakePolEff_reg ? brakeInput : ~brakeInput);

    // readback image of the brake and dead time register
    assign brakeRead = {moe_reg, autoEn_reg, brakePol_reg, brakeEn_reg,
        runOff_reg, idleOff_reg, lock_reg, deadTime_reg};

    // read mux over the word reached by this access
    always_comb begin
        accRead = 16'h0000;
        if (accValid) begin
            if (accIdx[4:0] == BRAKE_IDX) begin
                accRead = brakeRead;
            end else if (accIdx[4:0] == DMA_IDX) begin
                accRead = dmaCtrl_reg;
            end else begin
                accRead = timerRegs[accIdx[4:0]];
            end
        end
    end

    // burst index moves on each port access and wraps after the last
    always_comb begin
        burstIdx_next = burstIdx_reg;
        if (take & isPort) begin
            if (burstIdx_reg >= lenField) begin
                burstIdx_next = 5'h00;
            end else begin
                burstIdx_next = burstIdx_reg + 5'h01;
            end
        end
    end

    // wishbone answer: ack and read data registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
            rdData_reg <= 32'h00000000;
        end else begin
            ack_reg <= take;
            if (take & ~wb_we_i) begin
                rdData_reg <= {16'h0000, accRead};
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdData_reg;

    // burst index state
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            burstIdx_reg <= 5'h00;
        end else begin
            burstIdx_reg <= burstIdx_next;
        end
    end

    // plain timer registers written directly or by burst steps
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int i = 0; i < tbd_pkg::REG_COUNT; i++) begin
                timerRegs[i] <= 16'h0000;
            end
        end else if (swWrite & (accIdx[4:0] != BRAKE_IDX)
                & (accIdx[4:0] != DMA_IDX)) begin
            timerRegs[accIdx[4:0]] <= (timerRegs[accIdx[4:0]] & ~wrMask)
                | (wrData & wrMask);
        end
    end

    // burst control register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dmaCtrl_reg <= tbd_pkg::DMA_CTRL_RST;
        end else if (swWrite & (accIdx[4:0] == DMA_IDX)) begin
            dmaCtrl_reg <= ((dmaCtrl_reg & ~wrMask) | (wrData & wrMask))
                & tbd_pkg::DMA_CTRL_MASK;
        end
    end

    // lock level: writable once after reset, then frozen
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            lock_reg <= tbd_pkg::LOCK_NONE;
            lockDone_reg <= 1'b0;
        end else if (brakeWrite & wb_sel_i[1] & ~lockDone_reg) begin
            lock_reg <= wrData[tbd_pkg::LOCK_MSB:tbd_pkg::LOCK_LSB];
            lockDone_reg <= 1'b1;
        end
    end

    // dead time byte, frozen once any lock level is set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            deadTime_reg <= 8'h00;
        end else if (brakeWrite & wb_sel_i[0]
                & (lock_reg == tbd_pkg::LOCK_NONE)) begin
            deadTime_reg <= wrData[tbd_pkg::DT_MSB:tbd_pkg::DT_LSB];
        end
    end

    // brake enable, polarity and auto enable guarded by lock level one
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            brakeEn_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::BRAKE_ENABLE_BIT];
            brakePol_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::BRAKE_POLARITY_BIT];
            autoEn_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::AUTO_OUTPUT_ENABLE_BIT];
        end else if (brakeWrite & wb_sel_i[1]
                & (lock_reg == tbd_pkg::LOCK_NONE)) begin
            brakeEn_reg <= wrData[tbd_pkg::BRAKE_ENABLE_BIT];
            brakePol_reg <= wrData[tbd_pkg::BRAKE_POLARITY_BIT];
            autoEn_reg <= wrData[tbd_pkg::AUTO_OUTPUT_ENABLE_BIT];
        end
    end

    // off-state selects guarded by lock level two
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            idleOff_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::IDLE_OFFSTATE_SELECT_BIT];
            runOff_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::RUN_OFFSTATE_SELECT_BIT];
        end else if (brakeWrite & wb_sel_i[1]
                & (lock_reg < tbd_pkg::LOCK_TWO)) begin
            idleOff_reg <= wrData[tbd_pkg::IDLE_OFFSTATE_SELECT_BIT];
            runOff_reg <= wrData[tbd_pkg::RUN_OFFSTATE_SELECT_BIT];
        end
    end

    // polarity used by the brake path lags the written bit one clock
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            brakePolEff_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::BRAKE_POLARITY_BIT];
        end else begin
            brakePolEff_reg <= brakePol_reg;
        end
    end

    // main output enable: brake clears it without waiting for the clock
    always_ff @(posedge ref_clk or posedge brakeActive) begin
        if (brakeActive) begin
            moe_reg <= 1'b0;
        end else if (srst) begin
            moe_reg <= tbd_pkg::BRAKE_DT_RST[tbd_pkg::MAIN_OUTPUT_ENABLE_BIT];
        end else if (brakeWrite & wb_sel_i[1]) begin
            moe_reg <= wrData[tbd_pkg::MAIN_OUTPUT_ENABLE_BIT];
        end else if (updateEvent & autoEn_reg) begin
            moe_reg <= 1'b1;
        end
    end

    assign mainOutputOn = moe_reg;

    // per-channel output stages
    for (genvar c = 0; c < tbd_pkg::CHANNELS; c++) begin : g_chan
        tbd_chan_if chIf ();

        assign chIf.mainOn = moe_reg & ~brakeActive;
        assign chIf.runOff = runOff_reg;
        assign chIf.idleOff = idleOff_reg;
        assign chIf.enP = timerRegs[CHEN_IDX][c * tbd_pkg::CH_STRIDE
            + tbd_pkg::CH_EN_OFS];
        assign chIf.enN = timerRegs[CHEN_IDX][c * tbd_pkg::CH_STRIDE
            + tbd_pkg::CH_NEN_OFS];
        assign chIf.polP = timerRegs[CHEN_IDX][c * tbd_pkg::CH_STRIDE
            + tbd_pkg::CH_POL_OFS];
        assign chIf.polN = timerRegs[CHEN_IDX][c * tbd_pkg::CH_STRIDE
            + tbd_pkg::CH_NPOL_OFS];
        assign chIf.idleP = timerRegs[CTWO_IDX][tbd_pkg::IDLE_LSB
            + c * tbd_pkg::IDLE_STRIDE];
        assign chIf.idleN = timerRegs[CTWO_IDX][tbd_pkg::IDLE_LSB
            + c * tbd_pkg::IDLE_STRIDE + 1];
        assign chIf.refWave = chanRef[c];

        tbd_chan_stage u_stage (
            .ref_clk(ref_clk),
            .srst(srst),
            .ch(chIf.stage)
        );

        assign channelPrimaryOutput[c] = chIf.outP;
        assign primaryOe[c] = chIf.oeP;
        assign channelComplOutput[c] = chIf.outN;
        assign complOe[c] = chIf.oeN;
    end
endmodule // tbd_brake_burst

// ### tbd_brake_burst_monitor.sv
// assertions on bus handshake, brake and output pins of the timer block
`timescale 1ns/100ps
module tbd_brake_burst_monitor (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic brakeInput,
    input wire logic updateEvent,
    input wire logic [3:0] chanRef,
    input wire logic [3:0] channelPrimaryOutput,
    input wire logic [3:0] primaryOe,
    input wire logic [3:0] channelComplOutput,
    input wire logic [3:0] complOe,
    input wire logic mainOutputOn
);
    logic take, wrFull, bdtWr, lkDone, brake_enable, brake_polarity, autoOn;
    logic idleOn, runOn, brkAct, brkPolD;
    logic [1:0] lock;
    logic [15:0] ccen;
    logic [3:0] enP, enN;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // requests taken and decoded control bits
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrFull = take && wb_we_i && wb_sel_i[1:0] == 2'h3;
    assign bdtWr = wrFull && wb_adr_i == tbd_pkg::BRAKE_DT_OFS;
    assign brkAct = brake_enable && brakeInput == brkPolD;
    assign enP = {ccen[12], ccen[8], ccen[4], ccen[0]};
    assign enN = {ccen[14], ccen[10], ccen[6], ccen[2]};
    // brake register shadow, honouring the write lock
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {lkDone, brake_enable, brake_polarity, autoOn, idleOn, runOn} <= 6'h00;
            lock <= 2'h0;
        end else if (bdtWr) begin
            lkDone <= 1'b1;
            if (!lkDone) begin
                lock <= wb_dat_i[9:8];
            end
            if (lock == 2'h0) begin
                {autoOn, brake_polarity, brake_enable} <= wb_dat_i[14:12];
            end
            if (lock < 2'h2) begin
                {runOn, idleOn} <= wb_dat_i[11:10];
            end
        end
    end
    // polarity seen by the brake path lags the write by one clock
    always_ff @(posedge ref_clk) begin
        brkPolD <= srst ? 1'b0 : brake_polarity;
    end
    // channel enable shadow
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ccen <= 16'h0000;
        end else if (wrFull && wb_adr_i == tbd_pkg::CHAN_EN_OFS) begin
            ccen <= wb_dat_i[15:0];
        end
    end
    ack_resp_a: assert property (
        take |=> wb_ack_o) else $error("request not answered");
    ack_pulse_a: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    ack_cause_a: assert property (
        $rose(wb_ack_o) |-> $past(take)) else $error("ack without request");
    moe_rise_a: assert property (
        $rose(mainOutputOn) |-> $past(updateEvent) ||
        $past(bdtWr && wb_dat_i[15])) else $error("main output set by itself");
    auto_rise_a: assert property (
        updateEvent && autoOn && !brkAct && !bdtWr ##1 !brkAct
        |-> mainOutputOn) else $error("update did not set main output");
    brake_clear_a: assert property (
        brkAct |-> !mainOutputOn) else $error("main output on under brake");
    off_idle_a: assert property (
        (!mainOutputOn && !idleOn) [*2] |-> (primaryOe | complOe) == 4'h0)
        else $error("pins driven while main output off");
    run_gate_a: assert property (
        (mainOutputOn && !runOn) [*2] |-> ((primaryOe & ~$past(enP)) |
        (complOe & ~$past(enN))) == 4'h0) else $error("disabled pin driven");
    cover property (take && wb_adr_i == tbd_pkg::DATA_PORT_OFS);
    cover property ($fell(mainOutputOn) && brkAct);
    cover property (updateEvent && autoOn);
endmodule // tbd_brake_burst_monitor

// ### tbd_dma_model.sv
// bus master standing for the dma controller and software
`timescale 1ns/100ps
module tbd_dma_model (
    input wire logic ref_clk,
    input wire logic ackIn,
    input wire logic [31:0] datIn,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [31:0] dat,
    output logic [3:0] sel
);
    // idle bus at time zero
    initial begin
        {cyc, stb, we} = 3'h0;
        adr = 8'h00;
        dat = 32'h0000_0000;
        sel = 4'h0;
    end
    // one classic cycle; sel 4'h1 gives byte-wide dma items
    task automatic access(input logic w, input logic [7:0] a,
        input logic [3:0] s, input logic [15:0] wd, output logic [15:0] rd);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {16'h0000, wd};
        // ack and read data are taken at the same rising edge
        do begin
            @(posedge ref_clk);
        end while (ackIn !== 1'b1);
        rd = datIn[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        dat <= {16'h0000, ~wd};
        @(posedge ref_clk);
    endtask
endmodule // tbd_dma_model

// ### tbd_brake_burst_bench.sv
// self-checking bench of the brake and burst block
`timescale 1ns/100ps
module tbd_brake_burst_bench;
    logic refClk, srst, brake_input, upd, cyc, stb, we, ack, moe;
    logic [7:0] adr;
    logic [31:0] datW, datR;
    logic [3:0] sel, ref4, pOut, pOe, nOut, nOe;
    logic [15:0] mem [32];
    logic [15:0] rd;
    int mismatches, cmp_count, cycles;
    tbd_brake_burst i_dut (.ref_clk(refClk), .srst(srst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(datW),
        .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack), .brakeInput(brake_input),
        .updateEvent(upd), .chanRef(ref4), .channelPrimaryOutput(pOut),
        .primaryOe(pOe), .channelComplOutput(nOut), .complOe(nOe),
        .mainOutputOn(moe));
    tbd_dma_model i_dma (.ref_clk(refClk), .ackIn(ack), .datIn(datR),
        .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat(datW), .sel(sel));
    // clock and hang guard
    initial begin
        refClk = 1'b0;
        forever #4 refClk = ~refClk;
    end
    always @(posedge refClk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // register access with a model of the stored words
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] x;
        i_dma.access(1'b1, a, 4'h3, d, x);
        if (!a[7] && a != tbd_pkg::DATA_PORT_OFS) begin
            mem[a[6:2]] = (a == tbd_pkg::DMA_CTRL_OFS) ?
                d & tbd_pkg::DMA_CTRL_MASK : d;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [15:0] e);
        i_dma.access(1'b0, a, 4'h3, 16'h0000, rd);
        check(rd, e);
    endtask
    task automatic pins(input int n, input logic [15:0] m,
        input logic [15:0] e);
        repeat (n) @(posedge refClk);
        @(negedge refClk);
        check({pOe, nOe, pOut, nOut} & m, e);
        @(posedge refClk);
    endtask
    task automatic moeIs(input logic e);
        @(negedge refClk);
        check({15'h0000, moe}, {15'h0000, e});
        @(posedge refClk);
    endtask
    task automatic t_reset;
        rdc(tbd_pkg::BRAKE_DT_OFS, tbd_pkg::BRAKE_DT_RST);
        rdc(tbd_pkg::DMA_CTRL_OFS, tbd_pkg::DMA_CTRL_RST);
        wr(tbd_pkg::DMA_CTRL_OFS, 16'hFFFF);
        rdc(tbd_pkg::DMA_CTRL_OFS, 16'h1F1F);
        wr(8'h80, 16'h1234);
        rdc(8'h80, 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_burst_rd;
        for (int i = 0; i < 17; i++) wr(8'(i * 4), 16'h3C00 + 16'(i));
        wr(tbd_pkg::DMA_CTRL_OFS, 16'h1100);
        for (int i = 0; i < 36; i++) rdc(8'h4C, mem[i % 18]);
        $display("t_burst_rd done");
    endtask
    task automatic t_burst_wr;
        logic [15:0] x;
        wr(tbd_pkg::DMA_CTRL_OFS, 16'h0203);
        for (int i = 0; i < 6; i++) wr(8'h4C, 16'hA000 + 16'(i));
        rdc(8'h0C, 16'hA003);
        rdc(8'h10, 16'hA004);
        rdc(8'h14, 16'hA005);
        wr(tbd_pkg::DMA_CTRL_OFS, 16'h0116);
        for (int i = 0; i < 2; i++) begin
            i_dma.access(1'b1, 8'h4C, 4'h1, 16'hBBC0 + 16'(i), x);
        end
        rdc(8'h58, 16'h00C0);
        rdc(8'h5C, 16'h00C1);
        $display("t_burst_wr done");
    endtask
    task automatic t_pins;
        ref4 <= 4'hF;
        wr(tbd_pkg::CHAN_EN_OFS, 16'h0005);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h8000);
        pins(10, 16'hFF00, 16'h1100);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h0000);
        pins(2, 16'hFF00, 16'h0000);
        wr(tbd_pkg::CHAN_EN_OFS, 16'h0000);
        wr(tbd_pkg::CTRL_TWO_OFS, 16'h0300);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h0400);
        wr(tbd_pkg::CHAN_EN_OFS, 16'h0001);
        pins(1, 16'hFFFF, 16'h1100);
        pins(int'(tbd_pkg::DEAD_CYCLES) + 2, 16'hFFFF, 16'h1111);
        wr(tbd_pkg::CHAN_EN_OFS, 16'h0000);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h8800);
        wr(tbd_pkg::CHAN_EN_OFS, 16'h0001);
        pins(4, 16'hFFFF, 16'h1100);
        $display("t_pins done");
    endtask
    task automatic t_brake;
        brake_input <= 1'b0;
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h3000);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'hB000);
        moeIs(1'b1);
        brake_input <= 1'b1;
        moeIs(1'b0);
        brake_input <= 1'b0;
        moeIs(1'b0);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h1000);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h9000);
        moeIs(1'b0);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h0000);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h8000);
        moeIs(1'b1);
        $display("t_brake done");
    endtask
    task automatic t_auto;
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h4000);
        upd <= 1'b1;
        @(posedge refClk);
        upd <= 1'b0;
        moeIs(1'b1);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h0000);
        upd <= 1'b1;
        @(posedge refClk);
        upd <= 1'b0;
        moeIs(1'b0);
        $display("t_auto done");
    endtask
    task automatic t_lock;
        srst <= 1'b1;
        brake_input <= 1'b1;
        repeat (2) @(posedge refClk);
        srst <= 1'b0;
        @(posedge refClk);
        rdc(tbd_pkg::BRAKE_DT_OFS, 16'h0000);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h1100);
        wr(tbd_pkg::BRAKE_DT_OFS, 16'h6000);
        rdc(tbd_pkg::BRAKE_DT_OFS, 16'h1100);
        $display("t_lock done");
    endtask
    // main sequence
    initial begin
        srst = 1'b1;
        brake_input = 1'b1;
        upd = 1'b0;
        ref4 = 4'h0;
        mismatches = 0;
        cmp_count = 0;
        cycles = 0;
        for (int i = 0; i < 32; i++) mem[i] = 16'h0000;
        repeat (8) @(posedge refClk);
        srst <= 1'b0;
        @(posedge refClk);
        t_reset();
        t_burst_rd();
        t_burst_wr();
        t_pins();
        t_brake();
        t_auto();
        t_lock();
        test_done();
    end
endmodule // tbd_brake_burst_bench
bind tbd_brake_burst tbd_brake_burst_monitor i_mon (.ref_clk(ref_clk),
    .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .brakeInput(brakeInput), .updateEvent(updateEvent), .chanRef(chanRef),
    .channelPrimaryOutput(channelPrimaryOutput), .primaryOe(primaryOe),
    .channelComplOutput(channelComplOutput), .complOe(complOe),
    .mainOutputOn(mainOutputOn));
